// >>> verilog/trigger_capture_sequencer.sv
// Embedded logic analyser: sequential trigger, capture memory and stimulus outputs.
`timescale 1ns/1ps

// Overview of operation
// - Armed rises at least arm-delay after stimulus-valid.
// - Edge matches only when edge enable set.
// - Startup enable arms automatically after reset.
// - Startup disabled: idle until host arms.
// - Startup characters: 0, 1, R, F, X.
// - Stages are matched strictly in order.
// - Stages beyond configured count are ignored.
// - AND mode: all cared bits must match.
// - OR mode: any cared bit matches.
// - Don't-care bits never take part.
// - Pre-store code selects 0/25/50/75 percent.
// - Early trigger keeps only samples available.
// - Standard triggers take low monitor bits.
// - Input pipelining keeps data and trigger aligned.
// - Output pipelining only on stimulus, valid, armed.
// - Trigger pulse comes input depth plus five later.
// - Capture depth rounded up to supported size.
// - One to three compiled trigger stages.
// - Stimulus width up to 512 bits.
// - Inputs sampled on rising user clock edge.
// - Valid spans capture, drops before next one.
module trigger_capture_sequencer
  import trigger_capture_pkg::*;
#(
  parameter int MONITOR_WIDTH = 40,
  parameter int MONITOR_DEPTH = 1024,
  parameter int TRIGGER_WIDTH = 40,
  parameter int NUM_STAGES = 3,
  parameter bit STANDARD_TRIGGERS = 1,
  parameter int STIMULUS_WIDTH = 20,
  parameter int INPUT_PIPELINING = 3,
  parameter int OUTPUT_PIPELINING = 0,
  parameter int ARM_DELAY = 1,
  parameter bit EDGE_ENABLE = 1,
  parameter bit STARTUP_ENABLE = 0,
  parameter logic [1:0] STARTUP_NUM_STAGES = 2'h1,
  parameter logic [8*TRIGGER_WIDTH-1:0] startup_pattern_first = {TRIGGER_WIDTH{8'h58}},
  parameter logic [8*TRIGGER_WIDTH-1:0] startup_pattern_second = {TRIGGER_WIDTH{8'h58}},
  parameter logic [8*TRIGGER_WIDTH-1:0] startup_pattern_third = {TRIGGER_WIDTH{8'h58}},
  parameter logic [2:0] STARTUP_USE_AND = 3'h7,
  parameter logic [1:0] STARTUP_PRE_STORE = 2'h1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User design
  input wire logic [MONITOR_WIDTH-1:0] monitor_in,
  input wire logic [TRIGGER_WIDTH-1:0] trigger_in,
  output logic [STIMULUS_WIDTH-1:0] stimulus_out,
  output logic stimulus_valid,
  output logic armed,
  output logic trigger_event,
  // Host control
  input wire logic arm_req,
  input wire logic [STIMULUS_WIDTH-1:0] host_stimulus,
  input wire logic [1:0] host_num_stages,
  input wire logic [NUM_STAGES-1:0] host_use_and,
  input wire logic [1:0] host_pre_store,
  input wire logic [NUM_STAGES*TRIGGER_WIDTH-1:0] host_care,
  input wire logic [NUM_STAGES*TRIGGER_WIDTH-1:0] host_edge,
  input wire logic [NUM_STAGES*TRIGGER_WIDTH-1:0] host_level,
  output logic capture_busy,
  // Captured sample readout
  output logic [MONITOR_WIDTH-1:0] read_data,
  output logic read_valid,
  input wire logic read_ready
);

  function automatic int round_depth(input int d);
    int r;
    r = DEPTH_MIN;
    while (r < d) r = r * 2;
    return r;
  endfunction

  localparam int MEM_DEPTH = round_depth(MONITOR_DEPTH);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int QUARTER = MEM_DEPTH >> PRE_QUARTER_SHIFT;

  if (NUM_STAGES < 1 || NUM_STAGES > STAGES_MAX || STIMULUS_WIDTH < 1 ||
      STIMULUS_WIDTH > STIM_WIDTH_MAX || TRIGGER_WIDTH < 1 || TRIGGER_WIDTH > TRIG_WIDTH_MAX ||
      MONITOR_DEPTH < DEPTH_MIN || MONITOR_DEPTH > DEPTH_MAX || ARM_DELAY < 1 ||
      (STANDARD_TRIGGERS && MONITOR_WIDTH < TRIGGER_WIDTH) || INPUT_PIPELINING < 0 ||
      OUTPUT_PIPELINING < 0) begin : g_bad_config
    $error("trigger_capture_sequencer: unsupported parameter values");
  end

  function automatic logic [7:0] startup_char(input int s, input int i);
    case (s)
      0: return startup_pattern_first[8*i+:8];
      1: return startup_pattern_second[8*i+:8];
      default: return startup_pattern_third[8*i+:8];
    endcase
  endfunction

  // Decoded startup bit; field 2 is care, 1 is edge and 0 is level.
  function automatic logic startup_field(input int s, input int i, input int f);
    pat_bit_t p;
    p = decode_char(startup_char(s, i));
    return p[f];
  endfunction

  // Input pipeline: monitor and trigger take the same number of stages.
  logic [MONITOR_WIDTH-1:0] mon_pipe [INPUT_PIPELINING+1];
  logic [TRIGGER_WIDTH-1:0] trig_pipe [INPUT_PIPELINING+1];
  assign mon_pipe[0] = monitor_in;
  assign trig_pipe[0] = STANDARD_TRIGGERS ? monitor_in[TRIGGER_WIDTH-1:0] : trigger_in;

  for (genvar k = 0; k < INPUT_PIPELINING; k++) begin : g_in_pipe
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mon_pipe[k+1] <= '0;
        trig_pipe[k+1] <= '0;
      end else begin
        mon_pipe[k+1] <= mon_pipe[k];
        trig_pipe[k+1] <= trig_pipe[k];
      end
    end
  end

  // Sample registers: the stored sample and the matched sample are the same cycle.
  logic [MONITOR_WIDTH-1:0] mon_cur;
  logic [TRIGGER_WIDTH-1:0] trig_cur;
  logic [TRIGGER_WIDTH-1:0] trig_prev;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mon_cur <= '0;
      trig_cur <= '0;
      trig_prev <= '0;
    end else begin
      mon_cur <= mon_pipe[INPUT_PIPELINING];
      trig_cur <= trig_pipe[INPUT_PIPELINING];
      trig_prev <= trig_cur;
    end
  end

  // Active trigger configuration, loaded at arm time.
  cap_state_t state;
  logic startup_pending;
  logic [1:0] num_stages_q;
  logic [NUM_STAGES-1:0] use_and_q;
  logic [1:0] pre_store_q;
  logic [TRIGGER_WIDTH-1:0] care_q [NUM_STAGES];
  logic [TRIGGER_WIDTH-1:0] edge_q [NUM_STAGES];
  logic [TRIGGER_WIDTH-1:0] level_q [NUM_STAGES];
  logic start_arm;
  assign start_arm = (state == ST_IDLE) && (startup_pending || arm_req);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      num_stages_q <= 2'h1;
      use_and_q <= '1;
      pre_store_q <= 2'h0;
      for (int s = 0; s < NUM_STAGES; s++) begin
        care_q[s] <= '0;
        edge_q[s] <= '0;
        level_q[s] <= '0;
      end
    end else if (start_arm && startup_pending) begin
      num_stages_q <= STARTUP_NUM_STAGES;
      use_and_q <= STARTUP_USE_AND[NUM_STAGES-1:0];
      pre_store_q <= STARTUP_PRE_STORE;
      for (int s = 0; s < NUM_STAGES; s++) begin
        for (int i = 0; i < TRIGGER_WIDTH; i++) begin
          care_q[s][i] <= startup_field(s, i, 2);
          edge_q[s][i] <= startup_field(s, i, 1) & EDGE_ENABLE;
          level_q[s][i] <= startup_field(s, i, 0);
        end
      end
    end else if (start_arm) begin
      num_stages_q <= host_num_stages;
      use_and_q <= host_use_and;
      pre_store_q <= host_pre_store;
      for (int s = 0; s < NUM_STAGES; s++) begin
        care_q[s] <= host_care[s*TRIGGER_WIDTH+:TRIGGER_WIDTH];
        edge_q[s] <= host_edge[s*TRIGGER_WIDTH+:TRIGGER_WIDTH] & {TRIGGER_WIDTH{EDGE_ENABLE}};
        level_q[s] <= host_level[s*TRIGGER_WIDTH+:TRIGGER_WIDTH];
      end
    end
  end

  // Per-stage matchers.
  logic [NUM_STAGES-1:0] stage_hit;
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    logic [TRIGGER_WIDTH-1:0] bit_ok;
    assign bit_ok = (edge_q[s] & ((level_q[s] & trig_cur & ~trig_prev) |
                                  (~level_q[s] & ~trig_cur & trig_prev))) |
                    (~edge_q[s] & ~(trig_cur ^ level_q[s]));
    assign stage_hit[s] = use_and_q[s] ? &(bit_ok | ~care_q[s])
                                       : |(bit_ok & care_q[s]);
  end

  logic [1:0] stage_idx;
  logic cur_hit;
  logic last_stage;
  logic final_hit;
  always_comb begin
    cur_hit = 1'b0;
    for (int s = 0; s < NUM_STAGES; s++) begin
      if (stage_idx == s[1:0]) cur_hit = stage_hit[s];
    end
  end
  // A stage count of zero behaves as one; stages past the count are never looked at.
  assign last_stage = ({1'b0, stage_idx} + 3'h1) >= {1'b0, num_stages_q};
  assign final_hit = (state == ST_ARMED) && cur_hit && last_stage;

  // Capture memory and pointers.
  logic [MONITOR_WIDTH-1:0] mem [MEM_DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] pre_count;
  logic [AW:0] pre_target;
  logic [AW:0] post_left;
  logic [AW:0] rd_left;
  logic [ARM_DELAY > 1 ? $clog2(ARM_DELAY) : 1:0] delay_cnt;
  logic buf_in_ready;
  logic push;
  logic buf_empty;
  logic valid_q;
  logic armed_q;
  logic [STIMULUS_WIDTH-1:0] stim_q;

  assign pre_target = (AW+1)'(QUARTER * pre_store_q);
  assign push = (state == ST_READ) && (rd_left != '0) && buf_in_ready;

  always_ff @(posedge core_clk) begin
    if (state == ST_ARMED || state == ST_POST) mem[wr_ptr] <= mon_cur;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      startup_pending <= STARTUP_ENABLE;
      stage_idx <= STAGE_RESET;
      wr_ptr <= '0;
      rd_ptr <= '0;
      pre_count <= '0;
      post_left <= '0;
      rd_left <= '0;
      delay_cnt <= '0;
      valid_q <= 1'b0;
      armed_q <= 1'b0;
      stim_q <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_arm) begin
            state <= ST_STIM;
            startup_pending <= 1'b0;
            if (!startup_pending) stim_q <= host_stimulus;
            valid_q <= 1'b1;
            delay_cnt <= ($bits(delay_cnt))'(ARM_DELAY - 1);
            stage_idx <= STAGE_RESET;
            pre_count <= '0;
          end
        end
        ST_STIM: begin
          if (delay_cnt == '0) begin
            state <= ST_ARMED;
            armed_q <= 1'b1;
          end else begin
            delay_cnt <= delay_cnt - 1'b1;
          end
        end
        ST_ARMED: begin
          wr_ptr <= wr_ptr + 1'b1;
          if (final_hit) begin
            state <= ST_POST;
            armed_q <= 1'b0;
            // Only the samples actually seen since arming count as pre-store.
            post_left <= (AW+1)'(MEM_DEPTH - 1) - pre_count;
            rd_ptr <= wr_ptr - pre_count[AW-1:0];
          end else begin
            if (cur_hit) stage_idx <= stage_idx + 1'b1;
            if (pre_count < pre_target) pre_count <= pre_count + 1'b1;
          end
        end
        ST_POST: begin
          wr_ptr <= wr_ptr + 1'b1;
          post_left <= post_left - 1'b1;
          if (post_left == (AW+1)'(1)) begin
            state <= ST_READ;
            rd_left <= (AW+1)'(MEM_DEPTH);
          end
        end
        ST_READ: begin
          if (push) begin
            rd_ptr <= rd_ptr + 1'b1;
            rd_left <= rd_left - 1'b1;
          end
          if (rd_left == '0 && buf_empty) begin
            state <= ST_IDLE;
            valid_q <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign capture_busy = (state != ST_IDLE);

  // Two-entry readout buffer: a stalled reader halts the memory walk, nothing is lost.
  logic [MONITOR_WIDTH-1:0] buf0;
  logic [MONITOR_WIDTH-1:0] buf1;
  logic [1:0] buf_count;
  logic pop;
  assign buf_in_ready = (buf_count != 2'h2);
  assign buf_empty = (buf_count == 2'h0);
  assign read_valid = !buf_empty;
  assign read_data = buf0;
  assign pop = read_valid && read_ready;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf0 <= '0;
      buf1 <= '0;
      buf_count <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (buf_count == 2'h0) buf0 <= mem[rd_ptr];
          else buf1 <= mem[rd_ptr];
          buf_count <= buf_count + 2'h1;
        end
        2'b01: begin
          buf0 <= buf1;
          buf_count <= buf_count - 2'h1;
        end
        2'b11: begin
          if (buf_count == 2'h1) begin
            buf0 <= mem[rd_ptr];
          end else begin
            buf0 <= buf1;
            buf1 <= mem[rd_ptr];
          end
        end
        default: buf_count <= buf_count;
      endcase
    end
  end

  // Trigger pulse chain: fixed latency, never output-pipelined.
  logic [FIRE_CHAIN_LEN-1:0] fire_chain;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) fire_chain <= '0;
    else fire_chain <= {fire_chain[FIRE_CHAIN_LEN-2:0], final_hit};
  end
  assign trigger_event = fire_chain[FIRE_CHAIN_LEN-1];

  // Output pipeline delays stimulus, valid and armed together; trigger_event bypasses it.
  localparam int OW = STIMULUS_WIDTH + 2;
  logic [OW-1:0] out_pipe [OUTPUT_PIPELINING+1];
  assign out_pipe[0] = {stim_q, valid_q, armed_q};
  for (genvar k = 0; k < OUTPUT_PIPELINING; k++) begin : g_out_pipe
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) out_pipe[k+1] <= '0;
      else out_pipe[k+1] <= out_pipe[k];
    end
  end
  assign stimulus_out = out_pipe[OUTPUT_PIPELINING][OW-1:2];
  assign stimulus_valid = out_pipe[OUTPUT_PIPELINING][1];
  assign armed = out_pipe[OUTPUT_PIPELINING][0];

  // Helper counters read only by the checks below.
  logic [AW+1:0] cap_total;
  logic [AW+1:0] armed_cycles;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_total <= '0;
      armed_cycles <= '0;
    end else begin
      if (final_hit) cap_total <= (AW+2)'(pre_count) + 1'b1;
      else if (state == ST_POST) cap_total <= cap_total + 1'b1;
      if (state != ST_ARMED) armed_cycles <= '0;
      else if (armed_cycles != '1) armed_cycles <= armed_cycles + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_reader_stall;
    read_valid && !read_ready;
  endsequence

  a_arm_after_valid: assert property ($rose(armed_q) |-> $past(valid_q, ARM_DELAY))
    else $error("armed rose too soon after stimulus valid");
  a_edge_masked: assert property ((state == ST_ARMED) |-> (EDGE_ENABLE || edge_q[0] == '0))
    else $error("edge match active with edges disabled");
  a_startup_arms: assert property (startup_pending && state == ST_IDLE |=> state == ST_STIM)
    else $error("startup trigger did not arm");
  a_idle_waits: assert property (state == ST_IDLE && !startup_pending && !arm_req
                                 |=> state == ST_IDLE)
    else $error("left idle without an arm request");
  a_stage_order: assert property (state == ST_ARMED && !final_hit |=>
                                  stage_idx == $past(stage_idx) ||
                                  stage_idx == $past(stage_idx) + 2'h1)
    else $error("trigger stage skipped");
  a_stage_bound: assert property (state == ST_ARMED && num_stages_q != 2'h0
                                  |-> stage_idx < num_stages_q)
    else $error("stage beyond configured count");
  a_pre_bound: assert property (final_hit |-> pre_count <= pre_target &&
                                (AW+2)'(pre_count) <= armed_cycles)
    else $error("pre-store count out of range");
  a_trig_latency: assert property (final_hit |-> ##(FIRE_CHAIN_LEN) trigger_event ##1
                                   !trigger_event || $past(final_hit, FIRE_CHAIN_LEN))
    else $error("trigger pulse latency wrong");
  a_valid_span: assert property (state == ST_ARMED || state == ST_POST || state == ST_READ
                                 |-> valid_q && !(state != ST_ARMED && armed_q))
    else $error("stimulus valid dropped during capture");
  a_post_length: assert property ($rose(state == ST_READ) |-> cap_total == (AW+2)'(MEM_DEPTH))
    else $error("captured sample count differs from depth");
  a_buf_hold: assert property (s_reader_stall |=> read_valid && $stable(read_data))
    else $error("readout word lost while stalled");

endmodule

// >>> verilog/trigger_capture_pkg.sv
// Shared constants and types for the trigger capture sequencer.
package trigger_capture_pkg;

  // Configuration limits that the sequencer can serve.
  localparam int DEPTH_MIN = 1024;
  localparam int DEPTH_MAX = 16384;
  localparam int STAGES_MAX = 3;
  localparam int STIM_WIDTH_MAX = 512;
  localparam int TRIG_WIDTH_MAX = 40;

  // Cycles from a trigger condition leaving the input pipeline to the trigger pulse.
  localparam int TRIG_OUT_LAT = 5;
  // One of those cycles is the sample register in front of the matcher.
  localparam int FIRE_CHAIN_LEN = TRIG_OUT_LAT - 1;

  // Pre-store amount is a count of quarters of the capture depth.
  localparam int PRE_QUARTER_SHIFT = 2;

  // Pattern characters of the build-time startup trigger.
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_ONE = 8'h31;
  localparam logic [7:0] CHAR_RISE = 8'h52;
  localparam logic [7:0] CHAR_FALL = 8'h46;

  // Reset values.
  localparam logic [1:0] STAGE_RESET = 2'h0;

  // One decoded trigger bit: whether it counts, edge or level, and polarity.
  typedef struct packed {
    logic care;
    logic on_edge;
    logic level;
  } pat_bit_t;

  typedef enum logic [2:0] {ST_IDLE, ST_STIM, ST_ARMED, ST_POST, ST_READ} cap_state_t;

  // Any character not listed decodes as don't care.
  function automatic pat_bit_t decode_char(input logic [7:0] c);
    pat_bit_t p;
    p = '0;
    case (c)
      CHAR_ZERO: p = '{care: 1'b1, on_edge: 1'b0, level: 1'b0};
      CHAR_ONE: p = '{care: 1'b1, on_edge: 1'b0, level: 1'b1};
      CHAR_RISE: p = '{care: 1'b1, on_edge: 1'b1, level: 1'b1};
      CHAR_FALL: p = '{care: 1'b1, on_edge: 1'b1, level: 1'b0};
      default: p = '0;
    endcase
    return p;
  endfunction

endpackage

// >>> dv/user_logic_model.sv
// Behavioural model of the user design that feeds and watches the sequencer.
`timescale 1ns/1ps
module user_logic_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // From the sequencer
  input wire logic [19:0] stimulus_out,
  input wire logic stimulus_valid,
  // To the sequencer and the testbench
  output logic [39:0] monitor,
  output logic [19:0] stimulus_seen
);
  logic valid_prev;
  logic fresh;

  assign fresh = stimulus_valid && !valid_prev;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_prev <= 1'b0;
    end else begin
      valid_prev <= stimulus_valid;
    end
  end

  // Holding zero while stimuli are invalid and restarting on new stimuli makes every
  // stored sample, including those taken just before the count restarts, predictable.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor <= '0;
    end else begin
      monitor <= (fresh || !stimulus_valid) ? '0 : monitor + 40'h00_0000_0001;
    end
  end

  // Stimulus is taken only at the rising edge of valid, since it may wander elsewhere.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stimulus_seen <= '0;
    end else if (fresh) begin
      stimulus_seen <= stimulus_out;
    end
  end
endmodule

// >>> dv/trigger_capture_sequencer_test.sv
// Self-checking testbench for the trigger capture sequencer.
`timescale 1ns/1ps
module trigger_capture_sequencer_test;
  import trigger_capture_pkg::*;
  localparam logic [39:0] T3000 = 40'h00_0000_3000;
  localparam logic [39:0] LOW8 = 40'h00_0000_00ff;
  localparam logic [39:0] B89 = 40'h00_0000_0300;
  localparam logic [39:0] B9 = 40'h00_0000_0200;
  localparam int INPUT_PIPELINING_T = 3;
  logic core_clk, sys_rst, arm_req, read_ready;
  logic [19:0] host_stim, stim1, stim2, seen1, seen2;
  logic [1:0] nst, pre;
  logic [2:0] use_and;
  logic [119:0] care, edge_sel, level;
  logic [39:0] mon1, mon2, rd1, trig_bus;
  logic sv1, sv2, arm1, arm2, te1, te2, busy1, rv1;
  int n_mismatch = 0;
  int tests_run = 0;

  always #12.5 core_clk = ~core_clk;

  trigger_capture_sequencer #(.MONITOR_DEPTH(1024), .ARM_DELAY(1)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .monitor_in(mon1), .trigger_in(trig_bus),
    .stimulus_out(stim1), .stimulus_valid(sv1), .armed(arm1), .trigger_event(te1),
    .arm_req(arm_req), .host_stimulus(host_stim), .host_num_stages(nst),
    .host_use_and(use_and), .host_pre_store(pre), .host_care(care), .host_edge(edge_sel),
    .host_level(level), .capture_busy(busy1), .read_data(rd1), .read_valid(rv1),
    .read_ready(read_ready));
  // A second sequencer that arms itself from build-time patterns, built without edge
  // matching so that its falling-edge character acts as a plain level zero.
  trigger_capture_sequencer #(.STARTUP_ENABLE(1), .EDGE_ENABLE(0),
    .STARTUP_NUM_STAGES(2'h2),
    .startup_pattern_first({{31{8'h58}}, 8'h46, {8{8'h58}}}),
    .startup_pattern_second({{31{8'h58}}, 8'h31, {8{8'h58}}}),
    .startup_pattern_third({{27{8'h58}}, 8'h31, {12{8'h58}}}),
    .STARTUP_PRE_STORE(2'h0)) dut_boot (
    .core_clk(core_clk), .sys_rst(sys_rst), .monitor_in(mon2), .trigger_in(trig_bus),
    .stimulus_out(stim2), .stimulus_valid(sv2), .armed(arm2), .trigger_event(te2),
    .arm_req(arm_req), .host_stimulus(host_stim), .host_num_stages(nst),
    .host_use_and(use_and), .host_pre_store(pre), .host_care(care), .host_edge(edge_sel),
    .host_level(level), .capture_busy(), .read_data(), .read_valid(),
    .read_ready(read_ready));
  user_logic_model user1 (.core_clk(core_clk), .sys_rst(sys_rst), .stimulus_out(stim1),
    .stimulus_valid(sv1), .monitor(mon1), .stimulus_seen(seen1));
  user_logic_model user2 (.core_clk(core_clk), .sys_rst(sys_rst), .stimulus_out(stim2),
    .stimulus_valid(sv2), .monitor(mon2), .stimulus_seen(seen2));

  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask

  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // The self-arming unit must fire on its second pattern only, while the other stays idle.
  // Were edges still matched, the first stage would wait for a fall and fire far later.
  task automatic startup_run();
    int k;
    k = 0;
    while (mon2 !== 40'h00_0000_0100 && k < 1000) begin
      check(sv1, 1'b0);
      tick();
      k++;
    end
    guard(k, 1000);
    check(arm2, 1'b1);
    check(seen2, 20'h0_0000);
    k = 0;
    while (te2 !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    check(k, INPUT_PIPELINING_T + TRIG_OUT_LAT);
  endtask

  // One host-armed capture: arm, trigger, then drain the buffer under back-pressure.
  task automatic run_capture(input logic [1:0] n, input logic [2:0] a, input logic [1:0] p,
      input logic [119:0] c, input logic [119:0] e, input logic [119:0] l,
      input logic [39:0] t);
    logic [39:0] first, at_pre, exp_w;
    int k, w, req, tv, pre_exp, d;
    host_stim = 20'h5_a000 ^ t[19:0];
    nst = n;
    use_and = a;
    pre = p;
    care = c;
    edge_sel = e;
    level = l;
    arm_req = 1'b1;
    tick();
    arm_req = 1'b0;
    check(sv1, 1'b1);
    check(stim1, host_stim);
    check(arm1, 1'b0);
    tick();
    check(arm1, 1'b1);
    check(seen1, host_stim);
    k = 0;
    while (mon1 !== t && k < 20000) begin
      tick();
      k++;
    end
    guard(k, 20000);
    check(arm1, 1'b1);
    k = 0;
    while (te1 !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    check(k, INPUT_PIPELINING_T + TRIG_OUT_LAT);
    check(arm1, 1'b0);
    req = int'(p) * 256;
    tv = int'(t);
    // Samples stored since arming: the count up to the trigger plus the input path.
    pre_exp = (tv + INPUT_PIPELINING_T + 1 < req) ? tv + INPUT_PIPELINING_T + 1 : req;
    w = 0;
    k = 0;
    first = '0;
    at_pre = '0;
    while (w < 1024 && k < 5000) begin
      read_ready = (k % 3 != 2);
      check(sv1, 1'b1);
      if (rv1 === 1'b1 && read_ready) begin
        d = tv - pre_exp + w;
        exp_w = (d < 0) ? '0 : 40'(d);
        if (w == 0) first = rd1;
        if (w == pre_exp) at_pre = rd1;
        check(rd1, exp_w);
        w++;
      end
      tick();
      k++;
    end
    guard(k, 5000);
    read_ready = 1'b1;
    if (pre_exp == req) begin
      check(t - first, 40'(req));
    end else begin
      check(at_pre, t);
    end
    // Enough idle cycles that the user logic shows zeros when the next capture arms.
    repeat (4) tick();
    check(sv1, 1'b0);
    check(busy1, 1'b0);
  endtask

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    arm_req = 1'b0;
    read_ready = 1'b1;
    host_stim = '0;
    nst = 2'h1;
    use_and = 3'h7;
    pre = 2'h0;
    care = '0;
    edge_sel = '0;
    level = '0;
    // All ones on the dedicated bus would fire at once if it were not ignored.
    trig_bus = '1;
    repeat (4) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    startup_run();
    for (int p = 0; p < 4; p++) begin
      run_capture(2'h1, 3'h7, p[1:0], {80'h0, T3000}, '0, {80'h0, T3000}, T3000);
    end
    run_capture(2'h3, 3'h7, 2'h0, {3{LOW8}}, '0, {40'h20, 40'h05, 40'h10}, 40'h120);
    run_capture(2'h1, 3'h7, 2'h0, {3{LOW8}}, '0, {40'h20, 40'h05, 40'h30}, 40'h30);
    run_capture(2'h1, 3'h6, 2'h3, {80'h0, B89}, '0, {80'h0, B89}, 40'h100);
    run_capture(2'h1, 3'h7, 2'h0, {80'h0, B89}, '0, {80'h0, B89}, B89);
    run_capture(2'h1, 3'h7, 2'h0, {80'h0, B9}, {80'h0, B9}, {80'h0, B9}, B9);
    run_capture(2'h1, 3'h7, 2'h0, {80'h0, B9}, {80'h0, B9}, '0, 40'h400);
    final_report();
  end
endmodule
